// *** shared/hfa_defs.svh ***
/*
 Timing constants and pin layout for the host-side controller of an 8-bit
 half-flash converter. Assumes a 125 MHz system clock.
*/
// Functional notes
// - Host picks the mode: long read waits, short read is pipelined.
// - Pipelined: a further read is needed to fetch each result.
// - Pipelined: host leaves at least 2.5 us between reads.
// - Wait request is open drain only; it needs an external pull-up.
// - Host allows 2 us conversion plus 500 ns recovery between samples.
// - Host holds chip select low for every access it intends.
`ifndef HFA_DEFS_SVH
`define HFA_DEFS_SVH
`define HFA_CLK_MHZ 125
`define HFA_TCONV_NS 2000
`define HFA_TREC_NS 500
`define HFA_TPIPE_NS 2500
`define HFA_TSETUP_NS 16
`define HFA_SETUP_CYC ((`HFA_TSETUP_NS * `HFA_CLK_MHZ + 999) / 1000)
`define HFA_REC_CYC ((`HFA_TREC_NS * `HFA_CLK_MHZ + 999) / 1000)
`define HFA_PIPE_CYC ((`HFA_TPIPE_NS * `HFA_CLK_MHZ + 999) / 1000)
`define HFA_TOUT_CYC ((2 * `HFA_TCONV_NS * `HFA_CLK_MHZ + 999) / 1000)
`define HFA_SHORT_CYC 4
`define HFA_CNT_W 10
`define HFA_CH_W 3
`endif

// *** shared/hfa_pkg.sv ***
/*
 Types shared by the host controller. Assumes hfa_defs.svh is on the path.
*/
package hfa_pkg;
	typedef enum logic [2:0] {
		HFA_IDLE,
		HFA_SETUP,
		HFA_STROBE,
		HFA_WAITR,
		HFA_RECOVER
	} hfa_state_e;
	typedef logic [7:0] hfa_data_t;
	typedef logic [2:0] hfa_chan_t;
endpackage : hfa_pkg

// *** logic/hfa_sync.sv ***
/*
 Two-flop synchroniser for a bundle of pin inputs. Assumes one clock.
*/
`timescale 1ns/10ps
module hfa_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_q;

	always_comb
	begin
		next_stage1 = d;
		next_q = stage1;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			stage1 <= '0;
			q <= '0;
		end
		else
		begin
			stage1 <= next_stage1;
			q <= next_q;
		end
	end
endmodule : hfa_sync

// *** logic/hfa_host.sv ***
/*
 Host controller that drives a clockless 8-bit half-flash converter through
 its chip select, read strobe and channel address pins, in wait mode or in
 pipelined mode. Assumes the converter's result bus, done flag and pulled-up
 wait line arrive asynchronously; all three are synchronised here.
*/
`timescale 1ns/10ps
`include "hfa_defs.svh"
module hfa_host (
	input wire logic clk,
	input wire logic nrst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_pipelined,
	input wire hfa_pkg::hfa_chan_t req_channel,
	output logic rsp_valid,
	output hfa_pkg::hfa_data_t rsp_data,
	output hfa_pkg::hfa_chan_t rsp_channel,
	output logic rsp_timeout,
	output logic chip_select_n,
	output logic read_strobe_n,
	output logic channel_sel_bit0,
	output logic channel_sel_bit1,
	output logic channel_sel_bit2,
	input wire logic [7:0] result_bus,
	input wire logic conversion_done_n,
	input wire logic wait_request_in
);
	import hfa_pkg::*;

	// ****************************************************************
	// Input synchronisation
	// ****************************************************************
	logic [9:0] pins_s;
	hfa_sync #(.W(10)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.d({wait_request_in, conversion_done_n, result_bus}),
		.q(pins_s)
	);
	logic done_s;
	logic wait_s;
	hfa_data_t bus_s;
	assign bus_s = pins_s[7:0];
	assign done_s = !pins_s[8];
	// The wait line is open drain; with no pull-up it floats, so done is
	// the authority and wait only shortens the wait when it is present.
	assign wait_s = pins_s[9];

	// ****************************************************************
	// Access sequencer
	// ****************************************************************
	hfa_state_e state;
	hfa_state_e next_state;
	logic [`HFA_CNT_W-1:0] cnt;
	logic [`HFA_CNT_W-1:0] next_cnt;
	logic pipe;
	logic next_pipe;
	hfa_chan_t chan;
	hfa_chan_t next_chan;
	hfa_chan_t prev_chan;
	hfa_chan_t next_prev_chan;
	logic cs_n;
	logic next_cs_n;
	logic rd_n;
	logic next_rd_n;
	logic vld;
	logic next_vld;
	logic tout;
	logic next_tout;
	hfa_data_t data;
	hfa_data_t next_data;
	hfa_chan_t rch;
	hfa_chan_t next_rch;
	logic fresh;
	logic next_fresh;

	function automatic logic [`HFA_CNT_W-1:0] cyc(input int n);
		cyc = `HFA_CNT_W'(n);
	endfunction : cyc

	always_comb
	begin
		next_state = state;
		next_cnt = (cnt != '0) ? cnt - cyc(1) : cnt;
		next_pipe = pipe;
		next_chan = chan;
		next_prev_chan = prev_chan;
		next_cs_n = cs_n;
		next_rd_n = rd_n;
		next_vld = 1'b0;
		next_tout = tout;
		next_data = data;
		next_rch = rch;
		next_fresh = fresh;
		case (state)
			HFA_IDLE:
			begin
				if (req_valid)
				begin
					next_pipe = req_pipelined;
					next_chan = req_channel;
					next_cs_n = 1'b0;
					next_cnt = cyc(`HFA_SETUP_CYC);
					next_state = HFA_SETUP;
				end
			end
			HFA_SETUP:
			begin
				if (cnt == '0)
				begin
					next_rd_n = 1'b0;
					next_cnt = pipe ? cyc(`HFA_SHORT_CYC)
						: cyc(`HFA_TOUT_CYC);
					next_fresh = 1'b0;
					next_state = pipe ? HFA_STROBE : HFA_WAITR;
				end
			end
			HFA_STROBE:
			begin
				if (cnt == '0)
				begin
					next_data = bus_s;
					next_rch = prev_chan;
					next_prev_chan = chan;
					next_vld = 1'b1;
					next_tout = 1'b0;
					next_rd_n = 1'b1;
					next_cs_n = 1'b1;
					next_cnt = cyc(`HFA_PIPE_CYC);
					next_state = HFA_RECOVER;
				end
			end
			HFA_WAITR:
			begin
				// Done may still be low from a conversion that an earlier
				// pipelined read started, since it only rises at a rising strobe or select
				// edge. It counts once seen high in this read; until then
				// only a released wait line can end the read early.
				if (!done_s)
					next_fresh = 1'b1;
				if ((done_s && fresh)
					|| (wait_s && cnt < cyc(`HFA_TOUT_CYC - 4)))
				begin
					next_data = bus_s;
					next_rch = chan;
					next_prev_chan = chan;
					next_vld = 1'b1;
					next_tout = 1'b0;
					next_rd_n = 1'b1;
					next_cs_n = 1'b1;
					next_cnt = cyc(`HFA_REC_CYC);
					next_state = HFA_RECOVER;
				end
				else if (cnt == '0)
				begin
					next_tout = 1'b1;
					next_rd_n = 1'b1;
					next_cs_n = 1'b1;
					next_cnt = cyc(`HFA_REC_CYC);
					next_state = HFA_RECOVER;
				end
			end
			HFA_RECOVER:
			begin
				if (cnt == '0)
					next_state = HFA_IDLE;
			end
			default:
			begin
				next_state = HFA_IDLE;
				next_cs_n = 1'b1;
				next_rd_n = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state <= HFA_IDLE;
			cnt <= '0;
			pipe <= 1'b0;
			chan <= '0;
			prev_chan <= '0;
			cs_n <= 1'b1;
			rd_n <= 1'b1;
			vld <= 1'b0;
			tout <= 1'b0;
			data <= '0;
			rch <= '0;
			fresh <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			pipe <= next_pipe;
			chan <= next_chan;
			prev_chan <= next_prev_chan;
			cs_n <= next_cs_n;
			rd_n <= next_rd_n;
			vld <= next_vld;
			tout <= next_tout;
			data <= next_data;
			rch <= next_rch;
			fresh <= next_fresh;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign req_ready = (state == HFA_IDLE);
	assign chip_select_n = cs_n;
	assign read_strobe_n = rd_n;
	assign channel_sel_bit0 = chan[0];
	assign channel_sel_bit1 = chan[1];
	assign channel_sel_bit2 = chan[2];
	assign rsp_valid = vld;
	assign rsp_data = data;
	assign rsp_channel = rch;
	assign rsp_timeout = tout;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_strobe_in_select: assert property (@(posedge clk) disable iff (!nrst)
		!rd_n |-> !cs_n) else $error("Read strobe outside chip select.");
	a_pipe_short_read: assert property (@(posedge clk) disable iff (!nrst)
		$fell(rd_n) && pipe |-> !rd_n [*5] ##1 rd_n)
		else $error("Pipelined read not short.");
	a_pipe_spacing: assert property (@(posedge clk) disable iff (!nrst)
		$rose(cs_n) && pipe |-> cs_n [*8])
		else $error("Pipelined reads too close.");
	a_recover_gap: assert property (@(posedge clk) disable iff (!nrst)
		$rose(rd_n) |-> ##[64:314] (state == HFA_IDLE))
		else $error("Recovery interval wrong.");
	a_addr_stable: assert property (@(posedge clk) disable iff (!nrst)
		!cs_n && !$fell(cs_n) |-> $stable(chan))
		else $error("Address changed during access.");
	a_wait_ends_done: assert property (@(posedge clk) disable iff (!nrst)
		state == HFA_WAITR && done_s && fresh |=> vld && rd_n)
		else $error("Wait read not ended at done.");
	a_setup_before: assert property (@(posedge clk) disable iff (!nrst)
		$fell(cs_n) |-> rd_n [*2])
		else $error("Strobe before select setup.");
	a_pipe_data: assert property (@(posedge clk) disable iff (!nrst)
		state == HFA_STROBE && cnt == '0 |=> rsp_data == $past(bus_s))
		else $error("Pipelined data not captured.");
	c_wait_read: cover property (@(posedge clk) disable iff (!nrst)
		state == HFA_WAITR && done_s);
	c_pipe_read: cover property (@(posedge clk) disable iff (!nrst)
		state == HFA_STROBE && cnt == '0);
	c_timeout: cover property (@(posedge clk) disable iff (!nrst)
		$rose(tout));
endmodule : hfa_host

// *** sim/hfa_adc_model.sv ***
/*
 Behavioural model of the clockless converter at the far side of the host.
 Assumes the host's clk as a stand-in for the internal timing.
*/
`timescale 1ns/10ps
module hfa_adc_model (
	input wire logic clk,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic [2:0] chan,
	input wire logic [7:0] level,
	input wire logic stall,
	output logic [7:0] result_bus,
	output logic conversion_done_n,
	output logic wait_low
);
	// ****************
	// Conversion state
	// ****************
	logic cs_q = 1, rd_q = 1, busy = 0;
	logic [7:0] latch = 0, prev = 0, last = 0;
	logic [2:0] ch = 0;
	int cnt = 0, win = 0;
	wire sel = !chip_select_n && !read_strobe_n;
	wire drive = sel && (win > 0 || !busy);
	wire [7:0] val = (win > 0) ? prev : latch;
	// A floating bus shows the inverse of the last value, never a hold.
	assign result_bus = drive ? val : ~last;
	initial conversion_done_n = 1;
	initial wait_low = 0;
	always @(posedge clk)
	begin
		cs_q <= chip_select_n;
		rd_q <= read_strobe_n;
		if (drive)
			last <= val;
		if (win > 0)
			win <= win - 1;
		if (sel && !(!cs_q && !rd_q))
		begin
			ch <= chan;
			busy <= 1;
			cnt <= 0;
			prev <= latch;
			win <= 12;
		end
		else if (busy && !stall)
		begin
			cnt <= cnt + 1;
			if (cnt == 124)
				latch[7:4] <= (level + 8'(ch)) >> 4;
			if (cnt == 199)
			begin
				latch[3:0] <= 4'(level + 8'(ch));
				busy <= 0;
				conversion_done_n <= 0;
				wait_low <= 0;
			end
		end
		if ((!cs_q && chip_select_n) || (!rd_q && read_strobe_n))
			conversion_done_n <= 1;
		if (cs_q && !chip_select_n)
			wait_low <= 1;
		else if (!cs_q && chip_select_n)
			wait_low <= 0;
	end
endmodule : hfa_adc_model

// *** sim/tb_hfa_host.sv ***
/*
 Self-checking bench for hfa_host against the converter model.
 Assumes an external pull-up on the wait line.
*/
`timescale 1ns/10ps
module tb_hfa_host;
	import hfa_pkg::*;
	logic clk = 0, nrst = 0, req_valid = 0, req_pipelined = 0, stall = 0;
	logic req_ready, rsp_valid, rsp_timeout, chip_select_n, read_strobe_n;
	logic channel_sel_bit0, channel_sel_bit1, channel_sel_bit2;
	logic conversion_done_n, wait_low;
	hfa_chan_t req_channel = 0, rsp_channel, last_ch;
	hfa_data_t level = 0, rsp_data, last_val;
	logic [7:0] result_bus;
	int n_fail = 0, checked = 0, k;
	bit have_last = 0;
	wire wait_request_in = wait_low ? 1'b0 : 1'b1;
	always #4 clk = ~clk;
	hfa_host u_hfa_host (.clk(clk), .nrst(nrst), .req_valid(req_valid),
		.req_ready(req_ready), .req_pipelined(req_pipelined),
		.req_channel(req_channel), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_channel(rsp_channel),
		.rsp_timeout(rsp_timeout), .chip_select_n(chip_select_n),
		.read_strobe_n(read_strobe_n), .channel_sel_bit0(channel_sel_bit0),
		.channel_sel_bit1(channel_sel_bit1),
		.channel_sel_bit2(channel_sel_bit2), .result_bus(result_bus),
		.conversion_done_n(conversion_done_n),
		.wait_request_in(wait_request_in));
	hfa_adc_model u_hfa_adc_model (.clk(clk), .chip_select_n(chip_select_n),
		.read_strobe_n(read_strobe_n),
		.chan({channel_sel_bit2, channel_sel_bit1, channel_sel_bit0}),
		.level(level), .stall(stall), .result_bus(result_bus),
		.conversion_done_n(conversion_done_n), .wait_low(wait_low));
	// *******
	// Helpers
	// *******
	function automatic hfa_data_t conv(input hfa_data_t lv, input hfa_chan_t c);
		return lv + 8'(c);
	endfunction : conv
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up;
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	task automatic run(input logic pip, input hfa_chan_t c, input logic st);
		int i;
		for (i = 0; i < 400 && req_ready !== 1'b1; i++)
			@(posedge clk) #1;
		level = 8'($urandom);
		stall = st;
		req_pipelined = pip;
		req_channel = c;
		req_valid = 1;
		@(posedge clk) #1;
		req_valid = 0;
		@(posedge clk) #1;
		check({5'h0, channel_sel_bit2, channel_sel_bit1, channel_sel_bit0},
			{5'h0, c});
		check({7'h0, chip_select_n}, 8'h0);
		check({7'h0, read_strobe_n}, 8'h1);
		for (i = 0; i < 2600; i++)
		begin
			@(posedge clk) #1;
			if (rsp_valid === 1'b1 || (st && rsp_timeout === 1'b1))
				break;
		end
		check({6'h0, chip_select_n, read_strobe_n}, 8'h3);
		if (st)
			check({6'h0, rsp_timeout, rsp_valid}, 8'h2);
		else
		begin
			check({7'h0, req_ready}, 8'h0);
			check({7'h0, rsp_timeout}, 8'h0);
			check({7'h0, pip ? i < 12 : i > 195}, 8'h1);
			if (!pip)
			begin
				check(rsp_data, conv(level, c));
				check({5'h0, rsp_channel}, {5'h0, c});
			end
			else if (have_last)
			begin
				check(rsp_data, last_val);
				check({5'h0, rsp_channel}, {5'h0, last_ch});
			end
			last_val = conv(level, c);
			last_ch = c;
			have_last = 1;
		end
	endtask : run
	// *****
	// Tests
	// *****
	initial
	begin
		void'($urandom(48879));
		repeat (5) @(posedge clk);
		#1 nrst = 1;
		run(1, 0, 0);
		run(1, 7, 0);
		run(0, 7, 0);
		run(0, 2, 1);
		run(1, 3, 0);
		run(0, 0, 0);
		for (k = 0; k < 24; k++)
			run(1'($urandom), 3'($urandom), 0);
		wrap_up();
	end
	initial
	begin
		#(60000 * 8);
		n_fail++;
		wrap_up();
	end
endmodule : tb_hfa_host
